//--- hw/cantlt_top.sv
// Purpose: test loop back pin control, timestamp counter, clock stop
//          handshake and write synchronization of the core control register
// Assumes: one clock; protocol engine outside delivers bit ticks and
//          frame start pulses
// Notes: core control writes settle after SYNC_STAGES+1 cycles
//
// What this block does
// - test pin paths cross through several flops
// - loopback makes own frames count as received
// - acknowledge errors ignored during loop back
// - external loop feeds tx to rx, pin ignored
// - loopback plus monitor selects internal loop
// - internal loop holds transmit pin recessive
// - sixteen bit timestamp counter wraps to zero
// - counter steps every N bit times, 1..16
// - value readable, any write clears counter
// - wrap sets the timestamp wrap flag
// - frame start captures count into element timestamp
// - clearing stop request clears stop acknowledge
// - readback keeps old value until synchronized
// - configuration hold passes through write synchronization
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`include "cantlt_cfg.svh"

module cantlt_top
   import cantlt_pkg::*;
#(
   parameter int SYNC_STAGES = `CT_SYNC_STAGES,
   parameter int TS_WIDTH    = 16
) (
   input  wire logic                clk_in,
   input  wire logic                rst_n_in,
   input  wire logic                clk_en_in,
   input  wire logic [7:0]          addr_in,
   input  wire logic [31:0]         wdata_in,
   input  wire logic                wr_in,
   input  wire logic                rd_in,
   output logic      [31:0]         rdata_out,
   input  wire logic                pe_tx_in,
   output logic                     pe_rx_out,
   input  wire logic                ack_err_in,
   output logic                     ack_err_out,
   output logic                     self_receive_out,
   output logic                     config_hold_out,
   input  wire logic                can_rx_in,
   output logic                     can_tx_out,
   input  wire logic                bit_tick_in,
   input  wire logic                sof_rx_in,
   input  wire logic                sof_tx_in,
   output logic      [TS_WIDTH-1:0] rx_element_timestamp_out,
   output logic      [TS_WIDTH-1:0] tx_event_timestamp_out,
   output logic                     irq_out
);
   localparam logic [3:0] SYNC_LAST = 4'(SYNC_STAGES - 1);

   logic                  rst_s1_r;
   logic                  rst_n_sync;
   logic                  wr_core;
   logic                  wr_test;
   logic                  wr_tsval;
   logic                  rd_istat;
   cantlt_loop_type       loop_mode;
   cantlt_sync_type       sync_st_r;
   cantlt_sync_type       sync_st_nxt;
   logic [3:0]            sync_cnt_r;
   logic [3:0]            sync_cnt_nxt;
   logic [31:0]           sync_val_r;
   logic [31:0]           sync_val_nxt;
   logic [31:0]           core_r;
   logic [31:0]           core_nxt;
   logic [31:0]           test_r;
   logic [31:0]           test_nxt;
   logic [31:0]           tscfg_r;
   logic [31:0]           tscfg_nxt;
   logic [31:0]           stat_r;
   logic [31:0]           stat_nxt;
   logic [31:0]           mask_r;
   logic [31:0]           mask_nxt;
   logic [31:0]           rdata_nxt;
   logic                  irq_nxt;
   logic                  csa_r;
   logic                  csa_nxt;
   logic [SYNC_STAGES-1:0] txov_pipe_r;
   logic [SYNC_STAGES-1:0] txval_pipe_r;
   logic                  rxs1_r;
   logic                  rxs2_r;
   logic                  tx_nxt;
   logic                  rx_nxt;
   logic                  ack_nxt;
   logic [3:0]            presc_r;
   logic [3:0]            presc_nxt;
   logic                  ts_tick;
   logic [TS_WIDTH-1:0]   ts_r;
   logic [TS_WIDTH-1:0]   ts_nxt;
   logic [TS_WIDTH-1:0]   rx_element_timestamp_nxt;
   logic [TS_WIDTH-1:0]   tx_event_timestamp_nxt;

   // reset released through two flops; held off the clock enable so that
   // a frozen block still leaves reset cleanly
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_s1_r   <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_s1_r   <= 1'b1;
         rst_n_sync <= rst_s1_r;
      end
   end

   assign wr_core  = wr_in && (addr_in == `CT_OFS_CORE);
   assign wr_test  = wr_in && (addr_in == `CT_OFS_TEST);
   assign wr_tsval = wr_in && (addr_in == `CT_OFS_TSVAL);
   assign rd_istat = rd_in && (addr_in == `CT_OFS_ISTAT);

   // internal loop only when monitor is also on
   always_comb begin
      if (test_r[`CT_TEST_LOOP_BIT] && core_r[`CT_CORE_MON_BIT]) begin
         loop_mode = LOOP_INT;
      end else if (test_r[`CT_TEST_LOOP_BIT]) begin
         loop_mode = LOOP_EXT;
      end else begin
         loop_mode = LOOP_NONE;
      end
   end

   // core control: the written value waits in a holding word, so reads
   // show the settled copy only
   always_comb begin
      sync_st_nxt  = sync_st_r;
      sync_cnt_nxt = sync_cnt_r;
      sync_val_nxt = sync_val_r;
      core_nxt     = core_r;
      if (wr_core) begin
         sync_val_nxt = wdata_in & `CT_CORE_WMASK;
         sync_cnt_nxt = 4'h0;
         sync_st_nxt  = SYNC_BUSY;
      end else begin
         case (sync_st_r)
            SYNC_BUSY: begin
               if (sync_cnt_r == SYNC_LAST) begin
                  core_nxt    = sync_val_r;
                  sync_st_nxt = SYNC_IDLE;
               end else begin
                  sync_cnt_nxt = sync_cnt_r + 4'h1;
               end
            end
            default: begin
            end
         endcase
      end
      // acknowledge tracks the settled request
      csa_nxt = core_r[`CT_CORE_REQ_BIT];
   end

   // registers, status and read data
   always_comb begin
      test_nxt  = test_r;
      tscfg_nxt = tscfg_r;
      mask_nxt  = mask_r;
      rdata_nxt = `CT_ZERO32;
      if (wr_test) begin
         test_nxt = wdata_in & `CT_TEST_WMASK;
      end
      if (wr_in && (addr_in == `CT_OFS_TSCFG)) begin
         tscfg_nxt = {12'h000, wdata_in[`CT_TSCFG_MSB:`CT_TSCFG_LSB], 16'h0000};
      end
      if (wr_in && (addr_in == `CT_OFS_IMASK)) begin
         mask_nxt = wdata_in & `CT_IRQ_WMASK;
      end
      // set wins over the clear by read
      stat_nxt = rd_istat ? `CT_ZERO32 : stat_r;
      if (ts_tick && (&ts_r)) begin
         stat_nxt[`CT_IRQ_WRAP_BIT] = 1'b1;
      end
      irq_nxt = |(stat_nxt & mask_nxt);
      if (rd_in) begin
         if (addr_in == `CT_OFS_TEST) begin
            rdata_nxt = test_r;
            rdata_nxt[`CT_TEST_RXPIN_BIT] = rxs2_r;
         end else if (addr_in == `CT_OFS_CORE) begin
            rdata_nxt = core_r;
            rdata_nxt[`CT_CORE_ACK_BIT] = csa_r;
         end else if (addr_in == `CT_OFS_TSCFG) begin
            rdata_nxt = tscfg_r;
         end else if (addr_in == `CT_OFS_TSVAL) begin
            rdata_nxt = {{(32-TS_WIDTH){1'b0}}, ts_r};
         end else if (addr_in == `CT_OFS_ISTAT) begin
            rdata_nxt = stat_r;
         end else if (addr_in == `CT_OFS_IMASK) begin
            rdata_nxt = mask_r;
         end
      end
   end

   // pin paths; the tx override walks a flop chain like a domain crossing
   always_comb begin
      if (loop_mode == LOOP_INT) begin
         tx_nxt = `CT_RECESSIVE;
      end else if (txov_pipe_r[SYNC_STAGES-1]) begin
         tx_nxt = txval_pipe_r[SYNC_STAGES-1];
      end else begin
         tx_nxt = pe_tx_in;
      end
      if (loop_mode == LOOP_NONE) begin
         rx_nxt = can_rx_in;
      end else begin
         rx_nxt = pe_tx_in;
      end
      ack_nxt = ack_err_in && (loop_mode == LOOP_NONE);
   end

   // timestamp prescaler counts bit ticks up to the programmed N-1
   always_comb begin
      ts_tick   = bit_tick_in &&
                  (presc_r == tscfg_r[`CT_TSCFG_MSB:`CT_TSCFG_LSB]);
      presc_nxt = presc_r;
      ts_nxt    = ts_r;
      if (wr_tsval) begin
         presc_nxt = 4'h0;
         ts_nxt    = '0;
      end else if (ts_tick) begin
         presc_nxt = 4'h0;
         ts_nxt    = ts_r + TS_WIDTH'(1);
      end else if (bit_tick_in) begin
         presc_nxt = presc_r + 4'h1;
      end
      rx_element_timestamp_nxt = sof_rx_in ? ts_r : rx_element_timestamp_out;
      tx_event_timestamp_nxt = sof_tx_in ? ts_r : tx_event_timestamp_out;
   end

   always_ff @(posedge clk_in or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         sync_st_r                <= SYNC_IDLE;
         sync_cnt_r               <= 4'h0;
         sync_val_r               <= `CT_CORE_RST;
         core_r                   <= `CT_CORE_RST;
         csa_r                    <= 1'b0;
         test_r                   <= `CT_ZERO32;
         tscfg_r                  <= `CT_ZERO32;
         stat_r                   <= `CT_ZERO32;
         mask_r                   <= `CT_ZERO32;
         rdata_out                <= `CT_ZERO32;
         irq_out                  <= 1'b0;
         txov_pipe_r              <= '0;
         txval_pipe_r             <= '0;
         rxs1_r                   <= `CT_RECESSIVE;
         rxs2_r                   <= `CT_RECESSIVE;
         can_tx_out               <= `CT_RECESSIVE;
         pe_rx_out                <= `CT_RECESSIVE;
         ack_err_out              <= 1'b0;
         presc_r                  <= 4'h0;
         ts_r                     <= '0;
         rx_element_timestamp_out <= '0;
         tx_event_timestamp_out   <= '0;
      end else if (clk_en_in) begin
         sync_st_r    <= sync_st_nxt;
         sync_cnt_r   <= sync_cnt_nxt;
         sync_val_r   <= sync_val_nxt;
         core_r       <= core_nxt;
         csa_r        <= csa_nxt;
         test_r       <= test_nxt;
         tscfg_r      <= tscfg_nxt;
         stat_r       <= stat_nxt;
         mask_r       <= mask_nxt;
         rdata_out    <= rdata_nxt;
         irq_out      <= irq_nxt;
         txov_pipe_r  <= {txov_pipe_r[SYNC_STAGES-2:0],
                          test_r[`CT_TEST_TXOV_BIT]};
         txval_pipe_r <= {txval_pipe_r[SYNC_STAGES-2:0],
                          test_r[`CT_TEST_TXVAL_BIT]};
         rxs1_r       <= can_rx_in;
         rxs2_r       <= rxs1_r;
         can_tx_out   <= tx_nxt;
         pe_rx_out    <= rx_nxt;
         ack_err_out  <= ack_nxt;
         presc_r      <= presc_nxt;
         ts_r         <= ts_nxt;
         rx_element_timestamp_out <= rx_element_timestamp_nxt;
         tx_event_timestamp_out   <= tx_event_timestamp_nxt;
      end
   end

   // engine stores its own frames while loop back is on
   assign self_receive_out = test_r[`CT_TEST_LOOP_BIT];
   assign config_hold_out  = core_r[`CT_CORE_HOLD_BIT];

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_sync);

   readback_hold_a: assert property (
      (sync_st_r == SYNC_BUSY) && (sync_cnt_r != SYNC_LAST)
      |=> $stable(core_r)) else $error("core readback changed early");
   sync_done_a: assert property (
      (sync_st_r == SYNC_BUSY) && (sync_cnt_r == SYNC_LAST) && !wr_core
      && clk_en_in |=> core_r == $past(sync_val_r))
      else $error("synchronized write not applied");
   int_loop_tx_a: assert property (
      (loop_mode == LOOP_INT) && clk_en_in |=> can_tx_out)
      else $error("tx not recessive in internal loop");
   ext_loop_rx_a: assert property (
      (loop_mode != LOOP_NONE) && clk_en_in |=> pe_rx_out == $past(pe_tx_in))
      else $error("rx not fed from tx in loop back");
   normal_path_a: assert property (
      (loop_mode == LOOP_NONE) && clk_en_in
      |=> pe_rx_out == $past(can_rx_in))
      else $error("rx pin not connected in normal mode");
   ack_mask_a: assert property (
      (loop_mode != LOOP_NONE) && clk_en_in |=> !ack_err_out)
      else $error("ack error passed in loop back");
   ts_wrap_flag_a: assert property (
      ts_tick && (&ts_r) && !wr_tsval && clk_en_in
      |=> stat_r[`CT_IRQ_WRAP_BIT] && (ts_r == '0))
      else $error("wrap did not set flag");
   ts_clear_a: assert property (
      wr_tsval && clk_en_in |=> ts_r == '0)
      else $error("timestamp write did not clear");
   ts_step_a: assert property (
      !bit_tick_in && !wr_tsval |=> $stable(ts_r))
      else $error("timestamp moved without bit tick");
   rx_capture_a: assert property (
      sof_rx_in && clk_en_in |=> rx_element_timestamp_out == $past(ts_r))
      else $error("frame start capture wrong");
   stop_ack_a: assert property (
      !core_r[`CT_CORE_REQ_BIT] && clk_en_in |=> !csa_r)
      else $error("stop ack not cleared");

   ext_loop_c: cover property (loop_mode == LOOP_EXT ##1 sof_tx_in);
   int_loop_c: cover property (loop_mode == LOOP_INT);
   ts_wrap_c: cover property (ts_tick && (&ts_r));
   sync_done_c: cover property (sync_st_r == SYNC_BUSY ##1
                                sync_st_r == SYNC_IDLE);
endmodule

//--- shared/cantlt_cfg.svh
// Purpose: register offsets, field positions and reset values
// Assumes: included by bare name from the top module and the bench
// Notes: byte addresses on the plain register port
`ifndef CANTLT_CFG_SVH
`define CANTLT_CFG_SVH
`define CT_OFS_TEST       8'h10
`define CT_OFS_CORE       8'h18
`define CT_OFS_TSCFG      8'h20
`define CT_OFS_TSVAL      8'h24
`define CT_OFS_ISTAT      8'h50
`define CT_OFS_IMASK      8'h54
`define CT_TEST_LOOP_BIT  4
`define CT_TEST_TXOV_BIT  5
`define CT_TEST_TXVAL_BIT 6
`define CT_TEST_RXPIN_BIT 7
`define CT_TEST_WMASK     32'h0000_0070
`define CT_CORE_HOLD_BIT  0
`define CT_CORE_ACK_BIT   3
`define CT_CORE_REQ_BIT   4
`define CT_CORE_MON_BIT   5
`define CT_CORE_WMASK     32'h0000_0031
`define CT_CORE_RST       32'h0000_0001
`define CT_TSCFG_LSB      16
`define CT_TSCFG_MSB      19
`define CT_IRQ_WRAP_BIT   16
`define CT_IRQ_WMASK      32'h0001_0000
`define CT_SYNC_STAGES    3
`define CT_RECESSIVE      1'b1
`define CT_ZERO32         32'h0000_0000
`endif

//--- shared/cantlt_pkg.sv
// Purpose: types shared by the loop back and timestamp block
// Assumes: constants live in cantlt_cfg.svh
// Notes: no codes are given to the states
package cantlt_pkg;
   typedef enum logic [1:0] {LOOP_NONE, LOOP_EXT, LOOP_INT} cantlt_loop_type;
   typedef enum logic {SYNC_IDLE, SYNC_BUSY} cantlt_sync_type;
endpackage

//--- verification/cantlt_bus_model.sv
// Purpose: far side of the pins, a transceiver on a wired-and bus
// Assumes: other nodes pull the bus dominant through node_dom_in
// Notes: one cycle of transceiver delay; the bus idles recessive
`timescale 1ns/10ps

module cantlt_bus_model (
   input  wire logic clk_in,
   input  wire logic tx_in,
   input  wire logic node_dom_in,
   output logic      rx_out
);
   logic bus_r = 1'b1;

   // dominant wins, so the own transmitter is only heard when others idle
   always @(posedge clk_in) begin
      bus_r <= tx_in & ~node_dom_in;
   end
   assign rx_out = bus_r;
endmodule

//--- verification/cantlt_top_bench.sv
// Purpose: register level tests of loop back, pins, timestamp, clock stop
// Assumes: clk_en_in high except in the freeze test; engine side from bench
// Notes: wrap test ticks every cycle, so it runs about 66k cycles
`timescale 1ns/10ps
`include "cantlt_cfg.svh"

module cantlt_top_bench;
   logic        clk_in      = 1'b0;
   logic        rst_n_in    = 1'b0;
   logic        clk_en_in   = 1'b1;
   logic [7:0]  addr_in     = 8'h00;
   logic [31:0] wdata_in    = 32'h0000_0000;
   logic        wr_in       = 1'b0;
   logic        rd_in       = 1'b0;
   logic        pe_tx_in    = 1'b1;
   logic        ack_err_in  = 1'b0;
   logic        bit_tick_in = 1'b0;
   logic        sof_rx_in   = 1'b0;
   logic        sof_tx_in   = 1'b0;
   logic        node_dom    = 1'b0;
   logic        can_rx_in;
   logic        can_tx_out;
   logic        pe_rx_out;
   logic        ack_err_out;
   logic        self_receive_out;
   logic        config_hold_out;
   logic        irq_out;
   logic [31:0] rdata_out;
   logic [15:0] rx_ts;
   logic [15:0] tx_ts;
   int          fail_count   = 0;
   int          total_checks = 0;

   always #50 clk_in = ~clk_in;

   cantlt_top cantlt_top_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
      .rd_in(rd_in), .rdata_out(rdata_out), .pe_tx_in(pe_tx_in),
      .pe_rx_out(pe_rx_out), .ack_err_in(ack_err_in),
      .ack_err_out(ack_err_out), .self_receive_out(self_receive_out),
      .config_hold_out(config_hold_out), .can_rx_in(can_rx_in),
      .can_tx_out(can_tx_out), .bit_tick_in(bit_tick_in),
      .sof_rx_in(sof_rx_in), .sof_tx_in(sof_tx_in),
      .rx_element_timestamp_out(rx_ts), .tx_event_timestamp_out(tx_ts),
      .irq_out(irq_out));

   cantlt_bus_model cantlt_bus_model_i (
      .clk_in(clk_in), .tx_in(can_tx_out), .node_dom_in(node_dom),
      .rx_out(can_rx_in));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] got,
                        input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd_reg(input string name, input logic [7:0] a,
                         input logic [31:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      check(name, rdata_out, exp);
   endtask

   // expected bits: can_tx, pe_rx, ack_err
   task automatic pins(input logic tx, dom, ack, input logic [2:0] exp);
      @(posedge clk_in);
      pe_tx_in   <= tx;
      node_dom   <= dom;
      ack_err_in <= ack;
      cyc(5);
      check("pins", {29'h0, can_tx_out, pe_rx_out, ack_err_out},
            {29'h0, exp});
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_in);
         bit_tick_in <= 1'b1;
         @(posedge clk_in);
         bit_tick_in <= 1'b0;
      end
   endtask

   // cuts a hang short; the whole run needs about 66k of its 80k cycles
   initial begin
      #8_000_000;
      fail_count++;
      finish_test();
   end

   initial begin
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      cyc(3);
      check("tx_idle", {31'h0, can_tx_out}, 32'h0000_0001);
      rd_reg("core_rst", `CT_OFS_CORE, 32'h0000_0001);
      rd_reg("test_rst", `CT_OFS_TEST, 32'h0000_0080);
      rd_reg("unmapped", 8'h04, 32'h0000_0000);
      pins(1'b1, 1'b1, 1'b1, 3'b101);
      rd_reg("rx_pin", `CT_OFS_TEST, 32'h0000_0000);
      wr_reg(`CT_OFS_CORE, 32'h0000_0000);
      rd_reg("core_old", `CT_OFS_CORE, 32'h0000_0001);
      check("hold_old", {31'h0, config_hold_out}, 32'h0000_0001);
      cyc(4);
      rd_reg("core_new", `CT_OFS_CORE, 32'h0000_0000);
      check("hold_new", {31'h0, config_hold_out}, 32'h0000_0000);
      // self test modes, entered only here
      wr_reg(`CT_OFS_TEST, 32'h0000_0010);
      pins(1'b1, 1'b1, 1'b1, 3'b110);
      pins(1'b0, 1'b0, 1'b1, 3'b000);
      check("self_rx", {31'h0, self_receive_out}, 32'h0000_0001);
      wr_reg(`CT_OFS_CORE, 32'h0000_0020);
      pins(1'b1, 1'b1, 1'b1, 3'b110);
      pins(1'b0, 1'b0, 1'b1, 3'b100);
      wr_reg(`CT_OFS_CORE, 32'h0000_0000);
      wr_reg(`CT_OFS_TEST, 32'h0000_0000);
      pins(1'b1, 1'b0, 1'b0, 3'b110);
      wr_reg(`CT_OFS_TEST, 32'h0000_0020);
      @(negedge clk_in);
      check("tx_early", {31'h0, can_tx_out}, 32'h0000_0001);
      cyc(6);
      check("tx_forced", {31'h0, can_tx_out}, 32'h0000_0000);
      rd_reg("test_ovr", `CT_OFS_TEST, 32'h0000_0020);
      wr_reg(`CT_OFS_TEST, 32'h0000_0000);
      // timestamp with a prescale of two bit times
      wr_reg(`CT_OFS_TSCFG, 32'h0001_0000);
      wr_reg(`CT_OFS_TSVAL, 32'h0000_1234);
      tick(6);
      rd_reg("ts_count", `CT_OFS_TSVAL, 32'h0000_0003);
      @(posedge clk_in);
      sof_rx_in <= 1'b1;
      @(posedge clk_in);
      sof_rx_in <= 1'b0;
      cyc(1);
      check("rx_ts", {16'h0, rx_ts}, 32'h0000_0003);
      tick(2);
      @(posedge clk_in);
      sof_tx_in <= 1'b1;
      @(posedge clk_in);
      sof_tx_in <= 1'b0;
      cyc(1);
      check("tx_ts", {16'h0, tx_ts}, 32'h0000_0004);
      // wrap with one tick per cycle, interrupt masked at first
      wr_reg(`CT_OFS_TSCFG, 32'h0000_0000);
      wr_reg(`CT_OFS_TSVAL, 32'h0000_0000);
      @(posedge clk_in);
      bit_tick_in <= 1'b1;
      repeat (65535) @(posedge clk_in);
      bit_tick_in <= 1'b0;
      rd_reg("ts_max", `CT_OFS_TSVAL, 32'h0000_ffff);
      tick(1);
      cyc(2);
      rd_reg("ts_wrap", `CT_OFS_TSVAL, 32'h0000_0000);
      check("irq_mask", {31'h0, irq_out}, 32'h0000_0000);
      wr_reg(`CT_OFS_IMASK, 32'h0001_0000);
      cyc(2);
      check("irq_on", {31'h0, irq_out}, 32'h0000_0001);
      rd_reg("wrap_flag", `CT_OFS_ISTAT, 32'h0001_0000);
      cyc(2);
      check("irq_off", {31'h0, irq_out}, 32'h0000_0000);
      rd_reg("flag_clr", `CT_OFS_ISTAT, 32'h0000_0000);
      // a low enable freezes the counter even with ticks present
      @(posedge clk_in);
      clk_en_in   <= 1'b0;
      bit_tick_in <= 1'b1;
      cyc(4);
      @(posedge clk_in);
      clk_en_in   <= 1'b1;
      bit_tick_in <= 1'b0;
      rd_reg("ts_frozen", `CT_OFS_TSVAL, 32'h0000_0000);
      // clock stop entry and exit, clocks kept running throughout
      wr_reg(`CT_OFS_CORE, 32'h0000_0011);
      cyc(6);
      rd_reg("stop_ack", `CT_OFS_CORE, 32'h0000_0019);
      wr_reg(`CT_OFS_CORE, 32'h0000_0001);
      rd_reg("ack_kept", `CT_OFS_CORE, 32'h0000_0019);
      cyc(6);
      rd_reg("ack_gone", `CT_OFS_CORE, 32'h0000_0001);
      wr_reg(`CT_OFS_CORE, 32'h0000_0000);
      cyc(5);
      check("restart", {31'h0, config_hold_out}, 32'h0000_0000);
      finish_test();
   end
endmodule
